// *** design/gate_kill_pkg.sv ***
// Package: register map, field layout and carrier types for the fault shutdown block
package gate_kill_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] LEVEL_OFFSET = 8'h0c;
    localparam int OFFSET_W = 8;

    // ------------------------------------------------------------------
    // Fault channels: one index per fault source
    // ------------------------------------------------------------------
    localparam int FAULT_N = 3;
    localparam int FAULT_M1 = 0;
    localparam int FAULT_M2 = 1;
    localparam int FAULT_PFC = 2;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_POL_LSB = 0;
    localparam int CTRL_PIN_GPIO_BIT = 4;
    localparam int CTRL_GPIO_OUT_BIT = 5;
    localparam int CTRL_GPIO_DRIVE_BIT = 6;
    // Polarity 0 means the fault pin is active low
    localparam logic [FAULT_N-1:0] POL_RESET = 3'h0;
    localparam logic CTRL_BIT_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Level register fields
    // ------------------------------------------------------------------
    localparam int LEVEL_ACTIVE_LSB = 0;
    localparam int LEVEL_PIN_BIT = 4;

    // ------------------------------------------------------------------
    // Bus constants
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam logic HTRANS_ACTIVE_BIT = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [FAULT_N-1:0] FLAGS_ZERO = 3'h0;

    // Gate level that keeps a power switch off
    localparam logic GATE_OFF = 1'b0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic u_high_gate;
        logic u_low_gate;
        logic v_high_gate;
        logic v_low_gate;
        logic w_high_gate;
        logic w_low_gate;
    } motor_gates_t;

    localparam motor_gates_t GATES_OFF = '{default: GATE_OFF};

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ahb_req_t;

endpackage

// *** design/fault_qualifier.sv ***
// Fault qualifier: applies the programmed sense to one fault pin and flags its onset
`timescale 1ns/1ps

module fault_qualifier (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fault_pin_in,
    input wire logic polarity_in,
    output logic active_out,
    output logic onset_out
);

    logic active_prev_reg;

    // Combinational so the shutdown costs only the gate output flop
    assign active_out = (fault_pin_in == polarity_in);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            active_prev_reg <= 1'b0;
        end else begin
            active_prev_reg <= active_out;
        end
    end

    assign onset_out = active_out & ~active_prev_reg;

endmodule

// *** design/gate_kill.sv ***
// Gate kill top: fault shutdown of two motor bridges and the PFC switch, AHB-Lite registers
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Function
// R1: Motor-1 fault active forces six motor-1 gates off
// R2: Motor-2 fault active forces six motor-2 gates off
// R3: PFC fault forces PFC gate off, selectable polarity
// R4: PFC pin as GPIO: motor-1 fault kills PFC
// R5: Writable polarity bits; shutdown lasts while active
// ----------------------------------------------------------------------

module gate_kill (
    input wire logic clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Gate demands from the PWM generators
    input wire gate_kill_pkg::motor_gates_t m1_pwm_in,
    input wire gate_kill_pkg::motor_gates_t m2_pwm_in,
    input wire logic pfc_pwm_in,
    // Fault pins
    input wire logic motor1_fault_in,
    input wire logic motor2_fault_in,
    input wire logic pfc_fault_in,
    // Shared PFC fault pin used as discrete I/O
    output logic port5_bit0_io_out,
    output logic port5_bit0_io_oe_n_out,
    // Gate drive to the power stage
    output gate_kill_pkg::motor_gates_t m1_gates_out,
    output gate_kill_pkg::motor_gates_t m2_gates_out,
    output logic pfc_gate_out,
    output logic irq_out
);

    import gate_kill_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [FAULT_N-1:0] polarity_reg;
    logic pin_gpio_reg;
    logic gpio_out_reg;
    logic gpio_drive_reg;
    logic [FAULT_N-1:0] status_reg;
    logic [FAULT_N-1:0] status_next;
    logic [FAULT_N-1:0] mask_reg;
    logic [FAULT_N-1:0] mask_next;

    // ------------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------------
    ahb_req_t req;
    logic addr_valid;
    logic wr_pending_reg;
    logic [OFFSET_W-1:0] wr_offset_reg;
    logic [DATA_W-1:0] rdata_next;
    logic status_read;
    logic ctrl_write;

    assign req.haddr = haddr_in;
    assign req.htrans = htrans_in;
    assign req.hwrite = hwrite_in;
    assign req.hsize = hsize_in;
    assign req.hsel = hsel_in;
    assign req.hready = hready_in;

    // Zero wait states, so a transfer is taken whenever hready is seen high
    assign addr_valid = req.hsel & req.hready & (req.htrans[1] == HTRANS_ACTIVE_BIT);
    assign status_read = addr_valid & ~req.hwrite & (req.haddr[OFFSET_W-1:0] == STATUS_OFFSET);
    // Only whole-word transfers are expected, so hsize_in is not decoded
    assign ctrl_write = wr_pending_reg & (wr_offset_reg == CTRL_OFFSET);

    // ------------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------------
    logic [FAULT_N-1:0] fault_pin;
    logic [FAULT_N-1:0] fault_pol;
    logic [FAULT_N-1:0] fault_active;
    logic [FAULT_N-1:0] fault_onset;

    assign fault_pin[FAULT_M1] = motor1_fault_in;
    assign fault_pin[FAULT_M2] = motor2_fault_in;
    assign fault_pol[FAULT_M1] = polarity_reg[FAULT_M1];
    assign fault_pol[FAULT_M2] = polarity_reg[FAULT_M2];
    // Shared pin as GPIO: the PFC channel follows the motor-1 fault instead
    assign fault_pin[FAULT_PFC] = pin_gpio_reg ? motor1_fault_in : pfc_fault_in; // see R4
    assign fault_pol[FAULT_PFC] = pin_gpio_reg ? polarity_reg[FAULT_M1] : polarity_reg[FAULT_PFC]; // see R4

    // A polarity write can raise an onset; software clears status afterwards
    genvar gi;
    generate
        for (gi = 0; gi < FAULT_N; gi++) begin : g_qual
            fault_qualifier u_qual (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .fault_pin_in(fault_pin[gi]),
                .polarity_in(fault_pol[gi]), // see R5
                .active_out(fault_active[gi]),
                .onset_out(fault_onset[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------------
    // Held off every cycle the fault stays active; no latch, release is immediate
    // A fault pulse shorter than one clock can be missed; filter it upstream
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            m1_gates_out <= GATES_OFF;
        end else if (fault_active[FAULT_M1]) begin
            m1_gates_out <= GATES_OFF; // see R1, R5
        end else begin
            m1_gates_out <= m1_pwm_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            m2_gates_out <= GATES_OFF;
        end else if (fault_active[FAULT_M2]) begin
            m2_gates_out <= GATES_OFF; // see R2, R5
        end else begin
            m2_gates_out <= m2_pwm_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pfc_gate_out <= GATE_OFF;
        end else if (fault_active[FAULT_PFC]) begin
            pfc_gate_out <= GATE_OFF; // see R3, R4
        end else begin
            pfc_gate_out <= pfc_pwm_in;
        end
    end

    // ------------------------------------------------------------------
    // Discrete I/O on the shared pin
    // ------------------------------------------------------------------
    // Enable follows GPIO mode and the drive bit one cycle late; the pin stays driven for a cycle after GPIO mode clears
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port5_bit0_io_out <= CTRL_BIT_RESET;
        end else begin
            port5_bit0_io_out <= gpio_out_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port5_bit0_io_oe_n_out <= 1'b1;
        end else begin
            port5_bit0_io_oe_n_out <= ~(pin_gpio_reg & gpio_drive_reg);
        end
    end

    // ------------------------------------------------------------------
    // Write data phase
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_pending_reg <= 1'b0;
            wr_offset_reg <= CTRL_OFFSET;
        end else begin
            wr_pending_reg <= addr_valid & req.hwrite;
            wr_offset_reg <= req.haddr[OFFSET_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            polarity_reg <= POL_RESET;
        end else if (ctrl_write) begin
            polarity_reg <= hwdata_in[CTRL_POL_LSB +: FAULT_N]; // see R3, R5
        end
    end

    // Pin mode switches the PFC kill source in the same cycle it lands
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_gpio_reg <= CTRL_BIT_RESET;
        end else if (ctrl_write) begin
            pin_gpio_reg <= hwdata_in[CTRL_PIN_GPIO_BIT]; // see R4
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gpio_out_reg <= CTRL_BIT_RESET;
            gpio_drive_reg <= CTRL_BIT_RESET;
        end else if (ctrl_write) begin
            gpio_out_reg <= hwdata_in[CTRL_GPIO_OUT_BIT];
            gpio_drive_reg <= hwdata_in[CTRL_GPIO_DRIVE_BIT];
        end
    end

    always_comb begin
        mask_next = mask_reg;
        if (wr_pending_reg && wr_offset_reg == MASK_OFFSET) begin
            mask_next = hwdata_in[FAULT_N-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_reg <= FLAGS_ZERO;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------------
    // Sticky fault events, cleared by a read; a new onset wins
    // ------------------------------------------------------------------
    always_comb begin
        status_next = status_reg;
        if (status_read) begin
            status_next = FLAGS_ZERO;
        end
        status_next = status_next | fault_onset;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_reg <= FLAGS_ZERO;
        end else begin
            status_reg <= status_next;
        end
    end

    // Built from next values so the level tracks status in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_next & mask_next);
        end
    end

    // ------------------------------------------------------------------
    // Read data, captured in the address phase
    // ------------------------------------------------------------------
    // Unmapped offsets read zero; writes there are dropped
    always_comb begin
        rdata_next = DATA_ZERO;
        case (req.haddr[OFFSET_W-1:0])
            CTRL_OFFSET: begin
                rdata_next[CTRL_POL_LSB +: FAULT_N] = polarity_reg;
                rdata_next[CTRL_PIN_GPIO_BIT] = pin_gpio_reg;
                rdata_next[CTRL_GPIO_OUT_BIT] = gpio_out_reg;
                rdata_next[CTRL_GPIO_DRIVE_BIT] = gpio_drive_reg;
            end
            STATUS_OFFSET: begin
                rdata_next[FAULT_N-1:0] = status_reg;
            end
            MASK_OFFSET: begin
                rdata_next[FAULT_N-1:0] = mask_reg;
            end
            LEVEL_OFFSET: begin
                rdata_next[LEVEL_ACTIVE_LSB +: FAULT_N] = fault_active;
                rdata_next[LEVEL_PIN_BIT] = pfc_fault_in;
            end
            default: begin
                rdata_next = DATA_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hrdata_out <= DATA_ZERO;
        end else if (addr_valid && !req.hwrite) begin
            hrdata_out <= rdata_next;
        end
    end

    // Zero wait states and no error response: every transfer completes at once
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hreadyout_out <= 1'b1;
        end else begin
            hreadyout_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hresp_out <= HRESP_OKAY;
        end else begin
            hresp_out <= HRESP_OKAY;
        end
    end

endmodule

// *** sim/gate_kill_checker.sv ***
// Checker: gate shutdown against fault pins and the programmed sense
`timescale 1ns/1ps
module gate_kill_checker
    import gate_kill_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire gate_kill_pkg::motor_gates_t m1_pwm_in,
    input wire gate_kill_pkg::motor_gates_t m2_pwm_in,
    input wire logic pfc_pwm_in,
    input wire logic motor1_fault_in,
    input wire logic motor2_fault_in,
    input wire logic pfc_fault_in,
    input wire gate_kill_pkg::motor_gates_t m1_gates_out,
    input wire gate_kill_pkg::motor_gates_t m2_gates_out,
    input wire logic pfc_gate_out
);
    logic wr_phase_reg;
    logic [7:0] wr_addr_reg;
    logic [2:0] sense_reg;
    logic gpio_reg;
    wire m1_act = motor1_fault_in == sense_reg[0];
    wire m2_act = motor2_fault_in == sense_reg[1];
    wire pfc_act = gpio_reg ? m1_act : pfc_fault_in == sense_reg[2];
    // Mirror of the sense bits; takes effect at the data-phase edge
    always_ff @(posedge clk_in) begin
        wr_phase_reg <= !rst_in && hsel_in && hready_in && htrans_in[1] && hwrite_in;
        wr_addr_reg <= haddr_in[7:0];
        if (rst_in) begin
            sense_reg <= POL_RESET;
            gpio_reg <= CTRL_BIT_RESET;
        end else if (wr_phase_reg && wr_addr_reg == CTRL_OFFSET) begin
            sense_reg <= hwdata_in[2:0];
            gpio_reg <= hwdata_in[CTRL_PIN_GPIO_BIT];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_m1_held; m1_act [*3]; endsequence
    sequence s_m1_dark; m1_gates_out == GATES_OFF; endsequence
    a_m1_kill: assert property (m1_act |=> s_m1_dark) else $error("m1 gates on in fault");
    a_m1_pass: assert property (!rst_in && !m1_act |=> m1_gates_out == $past(m1_pwm_in)) else $error("m1 gates lost");
    a_m2_kill: assert property (m2_act |=> m2_gates_out == GATES_OFF) else $error("m2 gates on in fault");
    a_m2_pass: assert property (!rst_in && !m2_act |=> m2_gates_out == $past(m2_pwm_in)) else $error("m2 gates lost");
    a_pfc_kill: assert property (pfc_act |=> !pfc_gate_out) else $error("pfc gate on in fault");
    a_pfc_pass: assert property (!rst_in && !pfc_act |=> pfc_gate_out == $past(pfc_pwm_in)) else $error("pfc gate lost");
    a_gpio_kill: assert property (gpio_reg && m1_act |=> !pfc_gate_out) else $error("pfc on in gpio mode");
    a_kill_held: assert property (s_m1_held |=> s_m1_dark) else $error("m1 shutdown not held");
endmodule

// *** sim/fault_comparator_model.sv ***
// Far-side model: fault comparators that drive the sense pins
`timescale 1ns/1ps
module fault_comparator_model (
    input wire logic [2:0] trip_in,
    input wire logic [2:0] sense_in,
    output logic [2:0] pin_out
);
    // Tripped comparator drives the active level, else its inverse
    assign pin_out = ~(trip_in ^ sense_in);
endmodule

// *** sim/tb_gate_kill.sv ***
// Testbench: random fault and PWM traffic, register reads and interrupt
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_gate_kill;
    import gate_kill_pkg::*;
    logic clk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, pfc_pwm_in = 0, rnd = 0, gpio = 0;
    logic hreadyout_out, hresp_out, io_out, io_oe_n, pfc_gate_out, irq_out, pfc_pin;
    logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd_seen, exp_r;
    logic [1:0] htrans_in = 0;
    logic [2:0] trip = 0, pol = 0, pins;
    motor_gates_t m1_pwm_in = 0, m2_pwm_in = 0, m1_gates_out, m2_gates_out;
    logic [12:0] gq[$], exp_g;
    logic [31:0] rq[$];
    int n_mismatch = 0, num_checks = 0;
    event rd_ev;
    always #2 clk_in = ~clk_in;
    // Shared pin: design drives it only with its enable low
    assign pfc_pin = io_oe_n ? pins[2] : io_out;
    fault_comparator_model cmp_u (.trip_in(trip), .sense_in(pol), .pin_out(pins));
    gate_kill dut_u (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .m1_pwm_in(m1_pwm_in),
        .m2_pwm_in(m2_pwm_in), .pfc_pwm_in(pfc_pwm_in), .motor1_fault_in(pins[0]), .motor2_fault_in(pins[1]),
        .pfc_fault_in(pfc_pin), .port5_bit0_io_out(io_out), .port5_bit0_io_oe_n_out(io_oe_n),
        .m1_gates_out(m1_gates_out), .m2_gates_out(m2_gates_out), .pfc_gate_out(pfc_gate_out), .irq_out(irq_out));
    always @(posedge clk_in) begin
        {m1_pwm_in, m2_pwm_in, pfc_pwm_in} <= 13'($urandom);
        if (rnd)
            trip <= 3'($urandom);
    end
    always @(posedge clk_in) begin : note_gates
        logic a1, ap;
        a1 = pins[0] === pol[0];
        ap = gpio ? a1 : pfc_pin === pol[2];
        if (!rst_in)
            gq.push_back({a1 ? GATES_OFF : m1_pwm_in, pins[1] === pol[1] ? GATES_OFF : m2_pwm_in, !ap && pfc_pwm_in});
    end
    always @(negedge clk_in) begin
        if (gq.size() > 0) begin
            exp_g = gq.pop_front();
            `CHK("gates", exp_g, {m1_gates_out, m2_gates_out, pfc_gate_out})
        end
    end
    always @(rd_ev) begin
        if (rq.size() > 0) begin
            exp_r = rq.pop_front();
            `CHK("hrdata", exp_r, rd_seen)
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_ready();
        int k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (hreadyout_out !== 1'b1 && k < 50);
        if (k == 50) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr_in <= {24'h0, a};
        hwrite_in <= wr;
        htrans_in <= 2'b10;
        hsel_in <= 1'b1;
        wait_ready();
        htrans_in <= 2'b00;
        hsel_in <= 1'b0;
        hwdata_in <= d;
        wait_ready();
        if (wr && a == CTRL_OFFSET) begin
            pol <= d[2:0];
            gpio <= d[CTRL_PIN_GPIO_BIT];
        end
        rd_seen = hrdata_out;
        `CHK("hresp", HRESP_OKAY, hresp_out)
        if (!wr)
            -> rd_ev;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, DATA_ZERO);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clk_in);
        `CHK("irq", e, irq_out)
        @(posedge clk_in);
    endtask
    initial begin
        void'($urandom(32'h0a78a94d));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(CTRL_OFFSET, DATA_ZERO);
        rd(MASK_OFFSET, DATA_ZERO);
        rd(8'h10, DATA_ZERO);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, CTRL_OFFSET, {27'h0, c[3], 1'b0, c[2:0]});
            rnd <= 1'b1;
            repeat (30) @(posedge clk_in);
            rnd <= 1'b0;
        end
        @(posedge clk_in);
        trip <= 3'h0;
        bus(1'b1, CTRL_OFFSET, 32'h1);
        bus(1'b1, MASK_OFFSET, 32'h1);
        bus(1'b0, STATUS_OFFSET, DATA_ZERO);
        chk_irq(1'b0);
        trip <= 3'h1;
        repeat (2) @(posedge clk_in);
        chk_irq(1'b1);
        rd(STATUS_OFFSET, 32'h1);
        repeat (2) @(posedge clk_in);
        chk_irq(1'b0);
        // Masked event must still latch in status
        bus(1'b1, MASK_OFFSET, DATA_ZERO);
        trip <= 3'h0;
        repeat (2) @(posedge clk_in);
        trip <= 3'h1;
        repeat (2) @(posedge clk_in);
        chk_irq(1'b0);
        rd(STATUS_OFFSET, 32'h1);
        trip <= 3'h0;
        bus(1'b1, CTRL_OFFSET, 32'h11);
        bus(1'b0, STATUS_OFFSET, DATA_ZERO);
        trip <= 3'h1;
        repeat (2) @(posedge clk_in);
        rd(STATUS_OFFSET, 32'h5);
        rd(LEVEL_OFFSET, 32'h15);
        // Shared pin driven as output: its level reaches the pin bit of LEVEL
        bus(1'b1, CTRL_OFFSET, 32'h71);
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK("io", 2'b10, {io_out, io_oe_n})
        @(posedge clk_in);
        bus(1'b1, CTRL_OFFSET, 32'h51);
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK("io", 2'b00, {io_out, io_oe_n})
        @(posedge clk_in);
        rd(LEVEL_OFFSET, 32'h5);
        repeat (4) @(posedge clk_in);
        give_verdict();
    end
endmodule
bind gate_kill gate_kill_checker chk_u (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .m1_pwm_in(m1_pwm_in), .m2_pwm_in(m2_pwm_in), .pfc_pwm_in(pfc_pwm_in), .motor1_fault_in(motor1_fault_in),
    .motor2_fault_in(motor2_fault_in), .pfc_fault_in(pfc_fault_in), .m1_gates_out(m1_gates_out),
    .m2_gates_out(m2_gates_out), .pfc_gate_out(pfc_gate_out));
